/* hw/ipi_pkg.sv */
/*
  Constants, offsets and encodings shared by the inter-core interrupt unit,
  the core-side end and the link interface between them.
  Assumes one 125 MHz system clock and a synchronous active-high reset.
*/
package ipi_pkg;
  localparam int NUM_CORES  = 2;
  localparam int NUM_FIELDS = 8;
  localparam int FIELD_W    = 4;
  localparam int NUM_EXT    = 4;
  localparam int NUM_PER    = 4;
  localparam int DATA_W     = 32;
  localparam int ADDR_W     = 12;
  localparam int LEVEL_W    = 4;
  localparam int RANK_W     = 5;
  localparam int SRC_W      = 5;
  localparam int PER_STEP   = 8;

  localparam logic [ADDR_W-1:0] OFF_EXT_PRI  = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_ALLOC    = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_REQ0     = 12'h070;
  localparam logic [ADDR_W-1:0] OFF_REQ1     = 12'h074;
  localparam logic [ADDR_W-1:0] OFF_CLR0     = 12'h080;
  localparam logic [ADDR_W-1:0] OFF_CLR1     = 12'h084;
  localparam logic [ADDR_W-1:0] OFF_PRI0     = 12'h090;
  localparam logic [ADDR_W-1:0] OFF_PRI1     = 12'h094;
  localparam logic [ADDR_W-1:0] OFF_PRICLR0  = 12'h0A0;
  localparam logic [ADDR_W-1:0] OFF_PRICLR1  = 12'h0A4;
  localparam logic [ADDR_W-1:0] OFF_PER_PRI  = 12'h800;

  // allocation register fields
  localparam int ALLOC_EXT_TGT  = 0;
  localparam int ALLOC_PER_TGT  = 8;
  localparam int ALLOC_EXT_AUTO = 16;
  localparam int ALLOC_PER_AUTO = 17;
  localparam int ALLOC_MASK_UPD = 24;

  localparam logic [DATA_W-1:0]  RST_WORD  = 32'h0000_0000;
  localparam logic [RANK_W-1:0]  RANK_NONE = 5'h00;
  localparam logic [RANK_W-1:0]  RANK_PMAX = 5'h1E;
  localparam logic [RANK_W-1:0]  RANK_NMI  = 5'h1F;
  localparam logic [LEVEL_W-1:0] NMI_LEVEL = 4'hF;

  localparam logic [SRC_W-1:0] SRC_FIELD0 = 5'h00;
  localparam logic [SRC_W-1:0] SRC_EXT0   = 5'h08;
  localparam logic [SRC_W-1:0] SRC_PER0   = 5'h10;
  localparam logic [SRC_W-1:0] SRC_NMI    = 5'h1F;

  typedef enum logic [0:0] {
    CMD_IDLE,
    CMD_WAIT
  } cmd_state_type;
endpackage

/* hw/ipi_link_if.sv */
/*
  Link between the interrupt unit and the two cores: per-core register
  access port and per-core interrupt presentation and acceptance.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns
interface ipi_link_if;
  import ipi_pkg::*;
  logic [NUM_CORES-1:0]              reg_req;
  logic [NUM_CORES-1:0]              reg_we;
  logic [NUM_CORES-1:0][ADDR_W-1:0]  reg_addr;
  logic [NUM_CORES-1:0][DATA_W-1:0]  reg_wdata;
  logic [NUM_CORES-1:0][DATA_W-1:0]  reg_rdata;
  logic [NUM_CORES-1:0]              reg_ack;
  logic [NUM_CORES-1:0]              irq;
  logic [NUM_CORES-1:0][LEVEL_W-1:0] irq_level;
  logic [NUM_CORES-1:0][SRC_W-1:0]   irq_src;
  logic [NUM_CORES-1:0]              accept;
  logic [NUM_CORES-1:0]              mask_load;
  logic [NUM_CORES-1:0][LEVEL_W-1:0] mask_level;
  logic [NUM_CORES-1:0][LEVEL_W-1:0] core_level_mask;
  logic [NUM_CORES-1:0]              exception_block_bit;

  modport unit_mp (
    input  reg_req, reg_we, reg_addr, reg_wdata, accept, core_level_mask,
           exception_block_bit,
    output reg_rdata, reg_ack, irq, irq_level, irq_src, mask_load, mask_level
  );
  modport core_mp (
    output reg_req, reg_we, reg_addr, reg_wdata, accept, core_level_mask,
           exception_block_bit,
    input  reg_rdata, reg_ack, irq, irq_level, irq_src, mask_load, mask_level
  );
endinterface

/* hw/interrupt_unit.sv */
/*
  Interrupt unit end: request, clear and priority registers for the
  inter-core fields, external and peripheral priority arbitration and NMI.
  Assumes the core end drives the link on the same clock; the external,
  peripheral and NMI inputs are asynchronous pins.
*/
`timescale 1ns/1ns
module interrupt_unit (
  input  wire logic                              sys_clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              ce_i,
  input  wire logic [ipi_pkg::NUM_EXT-1:0]       ext_irq_i,
  input  wire logic [ipi_pkg::NUM_PER-1:0]       per_irq_i,
  input  wire logic                              nmi_i,
  output logic [ipi_pkg::NUM_CORES*ipi_pkg::NUM_FIELDS-1:0] ipi_field_source_o,
  ipi_link_if.unit_mp                            link
);
  import ipi_pkg::*;

  logic [NUM_CORES-1:0][DATA_W-1:0]  req_ff, nxt_req;
  logic [NUM_CORES-1:0][DATA_W-1:0]  pri_ff, nxt_pri;
  logic [DATA_W-1:0]                 ext_pri_ff, nxt_ext_pri;
  logic [DATA_W-1:0]                 per_pri_ff, nxt_per_pri;
  logic [DATA_W-1:0]                 alloc_ff, nxt_alloc;
  logic [NUM_CORES-1:0][DATA_W-1:0]  rdata_ff, nxt_rdata;
  logic [NUM_CORES-1:0]              ack_ff, nxt_ack;
  logic [NUM_CORES-1:0]              irq_ff, nxt_irq;
  logic [NUM_CORES-1:0][LEVEL_W-1:0] lvl_ff, nxt_lvl;
  logic [NUM_CORES-1:0][SRC_W-1:0]   src_ff, nxt_src;
  logic [NUM_CORES-1:0]              mload_ff, nxt_mload;
  logic [NUM_CORES-1:0][LEVEL_W-1:0] mlvl_ff, nxt_mlvl;
  logic [NUM_CORES*NUM_FIELDS-1:0]   fsrc_ff, nxt_fsrc;
  logic [NUM_EXT+NUM_PER:0]          sync1_ff, sync2_ff;
  logic                              nmi_prev_ff, nxt_nmi_prev;
  logic                              nmi_pend_ff, nxt_nmi_pend;

  // ceil(rank/2): thirty peripheral ranks fold onto fifteen mask levels
  function automatic logic [LEVEL_W-1:0] level_of(input logic [RANK_W-1:0] r);
    logic [RANK_W:0] s;
    s = {1'b0, r} + 6'h01;
    return s[LEVEL_W:1];
  endfunction

  function automatic logic hit(input logic [RANK_W-1:0] r,
                               input logic [RANK_W-1:0] best,
                               input logic [LEVEL_W-1:0] mask);
    return (r != RANK_NONE) && (r > best) && (level_of(r) > mask);
  endfunction

  always_comb begin
    logic [NUM_CORES-1:0][DATA_W-1:0] set_bits;
    logic [NUM_CORES-1:0][DATA_W-1:0] clr_bits;
    logic [NUM_CORES-1:0][DATA_W-1:0] pclr_bits;
    logic [RANK_W-1:0]                rank;
    logic [RANK_W-1:0]                best;
    logic [SRC_W-1:0]                 bsrc;
    logic                             tgt;
    logic                             auto_core;
    logic                             nmi_edge;
    set_bits     = '0;
    clr_bits     = '0;
    pclr_bits    = '0;
    rank         = RANK_NONE;
    best         = RANK_NONE;
    bsrc         = SRC_FIELD0;
    tgt          = 1'b0;
    auto_core    = 1'b0;
    nmi_edge     = 1'b0;
    nxt_pri      = pri_ff;
    nxt_ext_pri  = ext_pri_ff;
    nxt_per_pri  = per_pri_ff;
    nxt_alloc    = alloc_ff;
    nxt_rdata    = rdata_ff;
    nxt_ack      = '0;
    nxt_irq      = '0;
    nxt_lvl      = '0;
    nxt_src      = '0;
    nxt_mload    = '0;
    nxt_mlvl     = mlvl_ff;
    nxt_fsrc     = '0;
    // core 1 first so that core 0 wins a same-cycle write to a shared register
    for (int w = NUM_CORES - 1; w >= 0; w--) begin
      nxt_ack[w] = link.reg_req[w];
      if (link.reg_req[w] && link.reg_we[w]) begin
        case (link.reg_addr[w])
          // request and clear writes only raise bits, so a zero never drops another core's bit
          OFF_REQ0:    set_bits[0]  = set_bits[0] | link.reg_wdata[w];
          OFF_REQ1:    set_bits[1]  = set_bits[1] | link.reg_wdata[w];
          OFF_CLR0:    clr_bits[0]  = clr_bits[0] | link.reg_wdata[w];
          OFF_CLR1:    clr_bits[1]  = clr_bits[1] | link.reg_wdata[w];
          OFF_PRI0:    nxt_pri[0]   = link.reg_wdata[w];
          OFF_PRI1:    nxt_pri[1]   = link.reg_wdata[w];
          OFF_PRICLR0: pclr_bits[0] = pclr_bits[0] | link.reg_wdata[w];
          OFF_PRICLR1: pclr_bits[1] = pclr_bits[1] | link.reg_wdata[w];
          OFF_EXT_PRI: nxt_ext_pri  = link.reg_wdata[w];
          OFF_PER_PRI: nxt_per_pri  = link.reg_wdata[w];
          OFF_ALLOC:   nxt_alloc    = link.reg_wdata[w];
          default:     nxt_ack[w]   = link.reg_req[w];
        endcase
      end else if (link.reg_req[w]) begin
        case (link.reg_addr[w])
          OFF_REQ0:    nxt_rdata[w] = req_ff[0];
          OFF_REQ1:    nxt_rdata[w] = req_ff[1];
          OFF_PRI0:    nxt_rdata[w] = pri_ff[0];
          OFF_PRI1:    nxt_rdata[w] = pri_ff[1];
          OFF_EXT_PRI: nxt_rdata[w] = ext_pri_ff;
          OFF_PER_PRI: nxt_rdata[w] = per_pri_ff;
          OFF_ALLOC:   nxt_rdata[w] = alloc_ff;
          default:     nxt_rdata[w] = RST_WORD;
        endcase
      end
    end
    for (int c = 0; c < NUM_CORES; c++) begin
      // a set in the same cycle as its clear survives
      nxt_req[c] = (req_ff[c] & ~clr_bits[c]) | set_bits[c];
      nxt_pri[c] = nxt_pri[c] & ~pclr_bits[c];
    end
    nmi_edge     = sync2_ff[NUM_EXT+NUM_PER] & ~nmi_prev_ff;
    nxt_nmi_prev = sync2_ff[NUM_EXT+NUM_PER];
    nxt_nmi_pend = nmi_pend_ff;
    // automatic allocation sends to the core running at the lower mask level
    auto_core = link.core_level_mask[1] < link.core_level_mask[0];
    for (int c = 0; c < NUM_CORES; c++) begin
      best = RANK_NONE;
      bsrc = SRC_FIELD0;
      for (int f = 0; f < NUM_FIELDS; f++) begin
        nxt_fsrc[c*NUM_FIELDS+f] = &req_ff[c][f*FIELD_W +: FIELD_W];
        rank = {pri_ff[c][f*FIELD_W +: FIELD_W], 1'b0};
        if (nxt_fsrc[c*NUM_FIELDS+f] && hit(rank, best, link.core_level_mask[c])) begin
          best = rank;
          bsrc = SRC_FIELD0 + SRC_W'(f);
        end
      end
      for (int i = 0; i < NUM_EXT; i++) begin
        tgt  = alloc_ff[ALLOC_EXT_AUTO] ? auto_core : alloc_ff[ALLOC_EXT_TGT+i];
        rank = {ext_pri_ff[i*FIELD_W +: FIELD_W], 1'b0};
        if (sync2_ff[i] && (tgt == c[0]) && hit(rank, best, link.core_level_mask[c])) begin
          best = rank;
          bsrc = SRC_EXT0 + SRC_W'(i);
        end
      end
      for (int i = 0; i < NUM_PER; i++) begin
        tgt  = alloc_ff[ALLOC_PER_AUTO] ? auto_core : alloc_ff[ALLOC_PER_TGT+i];
        rank = per_pri_ff[i*PER_STEP +: RANK_W];
        if (rank > RANK_PMAX) begin
          rank = RANK_PMAX;
        end
        if (sync2_ff[NUM_EXT+i] && (tgt == c[0]) &&
            hit(rank, best, link.core_level_mask[c])) begin
          best = rank;
          bsrc = SRC_PER0 + SRC_W'(i);
        end
      end
      nxt_irq[c] = best != RANK_NONE;
      nxt_lvl[c] = level_of(best);
      nxt_src[c] = bsrc;
      // NMI goes to core 0, above every mask, but waits while blocked
      if (c == 0 && nmi_pend_ff && !link.exception_block_bit[0]) begin
        nxt_irq[c] = 1'b1;
        nxt_lvl[c] = NMI_LEVEL;
        nxt_src[c] = SRC_NMI;
      end
      if (link.accept[c] && irq_ff[c]) begin
        nxt_mload[c] = alloc_ff[ALLOC_MASK_UPD+c];
        nxt_mlvl[c]  = lvl_ff[c];
        if (c == 0 && src_ff[c] == SRC_NMI) begin
          nxt_nmi_pend = 1'b0;
        end
      end
    end
    if (nmi_edge) begin
      nxt_nmi_pend = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      req_ff      <= '0;
      pri_ff      <= '0;
      ext_pri_ff  <= RST_WORD;
      per_pri_ff  <= RST_WORD;
      alloc_ff    <= RST_WORD;
      rdata_ff    <= '0;
      ack_ff      <= '0;
      irq_ff      <= '0;
      lvl_ff      <= '0;
      src_ff      <= '0;
      mload_ff    <= '0;
      mlvl_ff     <= '0;
      fsrc_ff     <= '0;
      sync1_ff    <= '0;
      sync2_ff    <= '0;
      nmi_prev_ff <= 1'b0;
      nmi_pend_ff <= 1'b0;
    end else if (ce_i) begin
      req_ff      <= nxt_req;
      pri_ff      <= nxt_pri;
      ext_pri_ff  <= nxt_ext_pri;
      per_pri_ff  <= nxt_per_pri;
      alloc_ff    <= nxt_alloc;
      rdata_ff    <= nxt_rdata;
      ack_ff      <= nxt_ack;
      irq_ff      <= nxt_irq;
      lvl_ff      <= nxt_lvl;
      src_ff      <= nxt_src;
      mload_ff    <= nxt_mload;
      mlvl_ff     <= nxt_mlvl;
      fsrc_ff     <= nxt_fsrc;
      sync1_ff    <= {nmi_i, per_irq_i, ext_irq_i};
      sync2_ff    <= sync1_ff;
      nmi_prev_ff <= nxt_nmi_prev;
      nmi_pend_ff <= nxt_nmi_pend;
    end
  end

  assign link.reg_rdata      = rdata_ff;
  assign link.reg_ack        = ack_ff;
  assign link.irq            = irq_ff;
  assign link.irq_level      = lvl_ff;
  assign link.irq_src        = src_ff;
  assign link.mask_load      = mload_ff;
  assign link.mask_level     = mlvl_ff;
  assign ipi_field_source_o  = fsrc_ff;
endmodule

/* hw/core_end.sv */
/*
  Core-side end for two cores: turns user register commands into link
  accesses, holds each core's mask level and block bit, forwards accepts.
  Assumes the interrupt unit answers every access on the link.
*/
`timescale 1ns/1ns
module core_end (
  input  wire logic                                             sys_clk_i,
  input  wire logic                                             rst_i,
  input  wire logic                                             ce_i,
  input  wire logic [ipi_pkg::NUM_CORES-1:0]                    cmd_valid_i,
  input  wire logic [ipi_pkg::NUM_CORES-1:0]                    cmd_we_i,
  input  wire logic [ipi_pkg::NUM_CORES-1:0][ipi_pkg::ADDR_W-1:0] cmd_addr_i,
  input  wire logic [ipi_pkg::NUM_CORES-1:0][ipi_pkg::DATA_W-1:0] cmd_wdata_i,
  input  wire logic [ipi_pkg::NUM_CORES-1:0]                    accept_i,
  input  wire logic [ipi_pkg::NUM_CORES-1:0]                    status_set_i,
  input  wire logic [ipi_pkg::NUM_CORES-1:0][ipi_pkg::LEVEL_W-1:0] mask_value_i,
  input  wire logic [ipi_pkg::NUM_CORES-1:0]                    block_value_i,
  output logic [ipi_pkg::NUM_CORES-1:0]                         cmd_busy_o,
  output logic [ipi_pkg::NUM_CORES-1:0]                         rsp_valid_o,
  output logic [ipi_pkg::NUM_CORES-1:0][ipi_pkg::DATA_W-1:0]    rsp_rdata_o,
  output logic [ipi_pkg::NUM_CORES-1:0]                         irq_pending_o,
  output logic [ipi_pkg::NUM_CORES-1:0][ipi_pkg::LEVEL_W-1:0]   irq_level_o,
  output logic [ipi_pkg::NUM_CORES-1:0][ipi_pkg::SRC_W-1:0]     irq_src_o,
  output logic [ipi_pkg::NUM_CORES-1:0][ipi_pkg::LEVEL_W-1:0]   core_level_mask_o,
  ipi_link_if.core_mp                                           link
);
  import ipi_pkg::*;

  cmd_state_type [NUM_CORES-1:0]     st_ff, nxt_st;
  logic [NUM_CORES-1:0]              req_ff, nxt_req;
  logic [NUM_CORES-1:0]              we_ff, nxt_we;
  logic [NUM_CORES-1:0][ADDR_W-1:0]  addr_ff, nxt_addr;
  logic [NUM_CORES-1:0][DATA_W-1:0]  wdata_ff, nxt_wdata;
  logic [NUM_CORES-1:0]              busy_ff, nxt_busy;
  logic [NUM_CORES-1:0]              rsp_ff, nxt_rsp;
  logic [NUM_CORES-1:0][DATA_W-1:0]  rdata_ff, nxt_rdata;
  logic [NUM_CORES-1:0]              acc_ff, nxt_acc;
  logic [NUM_CORES-1:0][LEVEL_W-1:0] mask_ff, nxt_mask;
  logic [NUM_CORES-1:0]              blk_ff, nxt_blk;
  logic [NUM_CORES-1:0]              pend_ff;
  logic [NUM_CORES-1:0][LEVEL_W-1:0] lvl_ff;
  logic [NUM_CORES-1:0][SRC_W-1:0]   src_ff;

  always_comb begin
    nxt_st    = st_ff;
    nxt_req   = '0;
    nxt_we    = we_ff;
    nxt_addr  = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rsp   = '0;
    nxt_rdata = rdata_ff;
    nxt_acc   = '0;
    nxt_mask  = mask_ff;
    nxt_blk   = blk_ff;
    for (int c = 0; c < NUM_CORES; c++) begin
      case (st_ff[c])
        CMD_IDLE: begin
          // one access in flight per core; commands while busy are dropped
          if (cmd_valid_i[c]) begin
            nxt_req[c]   = 1'b1;
            nxt_we[c]    = cmd_we_i[c];
            nxt_addr[c]  = cmd_addr_i[c];
            nxt_wdata[c] = cmd_wdata_i[c];
            nxt_st[c]    = CMD_WAIT;
          end
        end
        CMD_WAIT: begin
          if (link.reg_ack[c]) begin
            nxt_rsp[c]   = 1'b1;
            nxt_rdata[c] = link.reg_rdata[c];
            nxt_st[c]    = CMD_IDLE;
          end
        end
        default: nxt_st[c] = CMD_IDLE;
      endcase
      nxt_acc[c] = accept_i[c] & link.irq[c];
      // a software status write overrides an automatic mask load
      if (status_set_i[c]) begin
        nxt_mask[c] = mask_value_i[c];
        nxt_blk[c]  = block_value_i[c];
      end else if (link.mask_load[c]) begin
        nxt_mask[c] = link.mask_level[c];
      end
    end
    for (int c = 0; c < NUM_CORES; c++) begin
      nxt_busy[c] = nxt_st[c] != CMD_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_CORES; c++) begin
        st_ff[c] <= CMD_IDLE;
      end
      req_ff   <= '0;
      we_ff    <= '0;
      addr_ff  <= '0;
      wdata_ff <= '0;
      busy_ff  <= '0;
      rsp_ff   <= '0;
      rdata_ff <= '0;
      acc_ff   <= '0;
      mask_ff  <= '0;
      blk_ff   <= '0;
      pend_ff  <= '0;
      lvl_ff   <= '0;
      src_ff   <= '0;
    end else if (ce_i) begin
      st_ff    <= nxt_st;
      req_ff   <= nxt_req;
      we_ff    <= nxt_we;
      addr_ff  <= nxt_addr;
      wdata_ff <= nxt_wdata;
      busy_ff  <= nxt_busy;
      rsp_ff   <= nxt_rsp;
      rdata_ff <= nxt_rdata;
      acc_ff   <= nxt_acc;
      mask_ff  <= nxt_mask;
      blk_ff   <= nxt_blk;
      pend_ff  <= link.irq;
      lvl_ff   <= link.irq_level;
      src_ff   <= link.irq_src;
    end
  end

  assign link.reg_req             = req_ff;
  assign link.reg_we              = we_ff;
  assign link.reg_addr            = addr_ff;
  assign link.reg_wdata           = wdata_ff;
  assign link.accept              = acc_ff;
  assign link.core_level_mask     = mask_ff;
  assign link.exception_block_bit = blk_ff;
  assign cmd_busy_o               = busy_ff;
  assign rsp_valid_o              = rsp_ff;
  assign rsp_rdata_o              = rdata_ff;
  assign irq_pending_o            = pend_ff;
  assign irq_level_o              = lvl_ff;
  assign irq_src_o                = src_ff;
  assign core_level_mask_o        = mask_ff;
endmodule

/* tb/ipi_props.sv */
/*
  Assertions on the link between the interrupt unit and the core end.
  Assumes one clock, clock enable held high, synchronous active-high reset.
*/
`timescale 1ns/1ns
module ipi_props (
  input  wire logic                                             sys_clk_i,
  input  wire logic                                             rst_i,
  input  wire logic [ipi_pkg::NUM_CORES-1:0]                    reg_req,
  input  wire logic [ipi_pkg::NUM_CORES-1:0]                    reg_ack,
  input  wire logic [ipi_pkg::NUM_CORES-1:0]                    irq,
  input  wire logic [ipi_pkg::NUM_CORES-1:0][ipi_pkg::LEVEL_W-1:0] irq_level,
  input  wire logic [ipi_pkg::NUM_CORES-1:0][ipi_pkg::SRC_W-1:0]   irq_src,
  input  wire logic [ipi_pkg::NUM_CORES-1:0]                    accept,
  input  wire logic [ipi_pkg::NUM_CORES-1:0]                    mask_load,
  input  wire logic [ipi_pkg::NUM_CORES-1:0][ipi_pkg::LEVEL_W-1:0] mask_level,
  input  wire logic [ipi_pkg::NUM_CORES-1:0][ipi_pkg::LEVEL_W-1:0] core_level_mask,
  input  wire logic [ipi_pkg::NUM_CORES-1:0]                    exception_block_bit
);
  import ipi_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_req_acked_c0: assert property (reg_req[0] |=> reg_ack[0])
    else $error("core 0 access not acked");
  a_req_acked_c1: assert property (reg_req[1] |=> reg_ack[1])
    else $error("core 1 access not acked");
  a_ack_has_req0: assert property (reg_ack[0] |-> $past(reg_req[0]))
    else $error("core 0 ack without access");
  a_ack_has_req1: assert property (reg_ack[1] |-> $past(reg_req[1]))
    else $error("core 1 ack without access");
  // core 1 never sees the NMI, so every level presented while its mask is stable must beat that mask
  a_level_over_mask: assert property (irq[1] && $stable(core_level_mask[1]) |-> irq_level[1] > core_level_mask[1])
    else $error("interrupt presented at or below mask");
  a_src_code_valid: assert property (irq[1] |-> irq_src[1] < 5'h0C || irq_src[1] inside {[5'h10:5'h13]})
    else $error("unknown source code presented");
  a_nmi_held_off: assert property ($past(exception_block_bit[0]) |-> !(irq[0] && irq_src[0] == SRC_NMI))
    else $error("NMI presented while blocked");
  a_nmi_top_level: assert property (irq[0] && irq_src[0] == SRC_NMI |-> irq_level[0] == NMI_LEVEL)
    else $error("NMI level wrong");
  a_mask_load_level: assert property (mask_load[1] |-> $past(accept[1]) && mask_level[1] == $past(irq_level[1]))
    else $error("mask load without matching accept");
endmodule

/* tb/tb_top.sv */
/*
  Testbench joining the interrupt unit and the core end over the link.
  Assumes clock enable held high; the bench drives the interrupt pins.
*/
`timescale 1ns/1ns
module tb_top;
  import ipi_pkg::*;
  logic                                sys_clk_i, rst_i, nmi;
  logic [NUM_CORES-1:0]                cmd_valid, cmd_we, accept, status_set, block_value;
  logic [NUM_CORES-1:0]                busy, rsp_valid, pending;
  logic [NUM_CORES-1:0][ADDR_W-1:0]    cmd_addr;
  logic [NUM_CORES-1:0][DATA_W-1:0]    cmd_wdata, rsp_rdata;
  logic [NUM_CORES-1:0][LEVEL_W-1:0]   mask_value, irq_lvl, mask_o;
  logic [NUM_CORES-1:0][SRC_W-1:0]     irq_src;
  logic [NUM_CORES*NUM_FIELDS-1:0]     field_src;
  logic [NUM_EXT-1:0]                  ext_irq;
  logic [NUM_PER-1:0]                  per_irq;
  int                                  errors, compares;
  ipi_link_if link_if();
  interrupt_unit interrupt_unit_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .ext_irq_i(ext_irq), .per_irq_i(per_irq), .nmi_i(nmi), .ipi_field_source_o(field_src),
    .link(link_if));
  core_end core_end_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .cmd_valid_i(cmd_valid), .cmd_we_i(cmd_we), .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
    .accept_i(accept), .status_set_i(status_set), .mask_value_i(mask_value),
    .block_value_i(block_value), .cmd_busy_o(busy), .rsp_valid_o(rsp_valid),
    .rsp_rdata_o(rsp_rdata), .irq_pending_o(pending), .irq_level_o(irq_lvl),
    .irq_src_o(irq_src), .core_level_mask_o(mask_o), .link(link_if));
  ipi_props ipi_props_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_req(link_if.reg_req),
    .reg_ack(link_if.reg_ack), .irq(link_if.irq), .irq_level(link_if.irq_level),
    .irq_src(link_if.irq_src), .accept(link_if.accept), .mask_load(link_if.mask_load),
    .mask_level(link_if.mask_level), .core_level_mask(link_if.core_level_mask),
    .exception_block_bit(link_if.exception_block_bit));

  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  task test_done;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one command, held for one edge, then a bounded wait for the response pulse
  task access(input int c, input logic we, input logic [11:0] a, input logic [31:0] d,
              output logic [31:0] rd);
    int n;
    @(posedge sys_clk_i);
    cmd_valid[c] <= 1'b1;
    cmd_we[c]    <= we;
    cmd_addr[c]  <= a;
    cmd_wdata[c] <= d;
    @(posedge sys_clk_i);
    cmd_valid[c] <= 1'b0;
    @(negedge sys_clk_i);
    check(busy[c], 32'h1);
    n = 0;
    while (n < 8 && rsp_valid[c] !== 1'b1) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n == 8) begin
      errors++;
      test_done();
    end else begin
      rd = rsp_rdata[c];
    end
  endtask

  task wr(input int c, input logic [11:0] a, input logic [31:0] d);
    logic [31:0] tmp;
    access(c, 1'b1, a, d, tmp);
  endtask

  task rd_chk(input int c, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] tmp;
    access(c, 1'b0, a, 32'h0000_0000, tmp);
    check(tmp, exp);
  endtask

  task settle;
    repeat (5) @(negedge sys_clk_i);
  endtask

  task pulse_accept(input int c);
    @(posedge sys_clk_i);
    accept[c] <= 1'b1;
    @(posedge sys_clk_i);
    accept[c] <= 1'b0;
    settle();
  endtask

  task status(input int c, input logic [3:0] m, input logic b);
    @(posedge sys_clk_i);
    status_set[c]  <= 1'b1;
    mask_value[c]  <= m;
    block_value[c] <= b;
    @(posedge sys_clk_i);
    status_set[c]  <= 1'b0;
    settle();
  endtask

  task s_reset;
    rd_chk(0, OFF_REQ0, 32'h0000_0000);
    rd_chk(1, OFF_REQ1, 32'h0000_0000);
    check(32'(field_src), 32'h0000_0000);
    rd_chk(0, 12'h3FC, 32'h0000_0000);
  endtask

  task s_field_and;
    wr(0, OFF_REQ0, 32'h0000_0001);
    settle();
    check(32'(field_src), 32'h0000_0000);
    wr(0, OFF_REQ0, 32'h0000_000E);
    rd_chk(0, OFF_REQ0, 32'h0000_000F);
    settle();
    check(32'(field_src), 32'h0000_0001);
    wr(1, OFF_REQ1, 32'h0000_00F0);
    settle();
    check(32'(field_src), 32'h0000_0201);
  endtask

  task s_clear;
    wr(0, OFF_CLR0, 32'h0000_0000);
    rd_chk(0, OFF_REQ0, 32'h0000_000F);
    wr(0, OFF_CLR0, 32'h0000_0001);
    rd_chk(0, OFF_REQ0, 32'h0000_000E);
    rd_chk(0, OFF_CLR0, 32'h0000_0000);
    settle();
    check(32'(field_src), 32'h0000_0200);
  endtask

  task s_priority;
    check(pending[1], 32'h0);
    wr(1, OFF_PRI1, 32'h0000_0030);
    settle();
    check(pending[1], 32'h1);
    check(irq_src[1], 32'h1);
    check(irq_lvl[1], 32'h3);
    wr(1, OFF_REQ1, 32'h0000_000F);
    wr(1, OFF_PRI1, 32'h0000_0035);
    settle();
    check(irq_src[1], 32'h0);
    check(irq_lvl[1], 32'h5);
    rd_chk(1, OFF_PRI1, 32'h0000_0035);
  endtask

  task s_accept;
    wr(1, OFF_ALLOC, 32'h0200_0000);
    pulse_accept(1);
    check(mask_o[1], 32'h5);
    check(pending[1], 32'h0);
    rd_chk(1, OFF_REQ1, 32'h0000_00FF);
  endtask

  task s_nmi;
    status(0, 4'h0, 1'b1);
    @(posedge sys_clk_i);
    nmi <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    nmi <= 1'b0;
    settle();
    check(pending[0], 32'h0);
    status(0, 4'h0, 1'b0);
    check(irq_src[0], 32'(SRC_NMI));
    check(irq_lvl[0], 32'(NMI_LEVEL));
    pulse_accept(0);
    check(pending[0], 32'h0);
  endtask

  // pin sources, peripheral clamp, fixed and automatic allocation
  task s_pins;
    wr(0, OFF_EXT_PRI, 32'h0000_0700);
    @(posedge sys_clk_i);
    ext_irq <= 4'h4;
    settle();
    check(irq_src[0], 32'h0A);
    check(irq_lvl[0], 32'h7);
    wr(0, OFF_PER_PRI, 32'h1F00_0000);
    @(posedge sys_clk_i);
    per_irq <= 4'h8;
    settle();
    check(irq_src[0], 32'h13);
    check(irq_lvl[0], 32'hF);
    wr(0, OFF_ALLOC, 32'h0000_0800);
    settle();
    check(irq_src[0], 32'h0A);
    check(irq_src[1], 32'h13);
    wr(0, OFF_ALLOC, 32'h0002_0000);
    settle();
    check(pending[1], 32'h0);
    check(irq_src[0], 32'h13);
    status(0, 4'h9, 1'b0);
    check(pending[0], 32'h0);
    check(irq_src[1], 32'h13);
    wr(1, OFF_PRICLR1, 32'h0000_000F);
    rd_chk(1, OFF_PRI1, 32'h0000_0030);
  endtask

  initial begin
    errors = 0;
    compares = 0;
    rst_i = 1'b1;
    nmi = 1'b0;
    ext_irq = '0;
    per_irq = '0;
    cmd_valid = '0;
    cmd_we = '0;
    cmd_addr = '0;
    cmd_wdata = '0;
    accept = '0;
    status_set = '0;
    mask_value = '0;
    block_value = '0;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    s_reset();
    s_field_and();
    s_clear();
    s_priority();
    s_accept();
    s_nmi();
    s_pins();
    test_done();
  end
endmodule
